// ---- src/aglfc_pkg.sv ----
// Constants for the accelerometer and gyroscope filter configuration block.
package aglfc_pkg;
	// Register offsets.
	localparam logic [7:0] ACCEL_CFG2_ADDR = 8'h1d;
	localparam logic [7:0] GYRO_LP_ADDR = 8'h1e;
	// Reset values of both registers.
	localparam logic [7:0] ACCEL_CFG2_RST = 8'h00;
	localparam logic [7:0] GYRO_LP_RST = 8'h00;
	// Writable bit masks; the remaining bits are reserved.
	localparam logic [7:0] ACCEL_CFG2_MASK = 8'h3f;
	localparam logic [7:0] GYRO_LP_MASK = 8'hf0;
	// Field positions.
	localparam int AVG_SEL_LSB = 4;
	localparam int BYPASS_BIT = 3;
	localparam int LPF_SEL_LSB = 0;
	localparam int GYRO_CYCLE_BIT = 7;
	localparam int GYRO_AVG_LSB = 4;
	// Filter output periods in microseconds.
	localparam int PERIOD_4K_US = 250;
	localparam int PERIOD_1K_US = 1000;
	// Accelerometer active window per averaging count, in microseconds.
	localparam int TON_1X_US = 1084;
	localparam int TON_4X_US = 1840;
	localparam int TON_8X_US = 2840;
	localparam int TON_16X_US = 4840;
	localparam int TON_32X_US = 8840;
	// Clock rate of sys_clk in cycles per microsecond.
	localparam int CLK_CYC_PER_US = 100;
	// Least averaging count exponent in accelerometer low-power mode.
	localparam logic [2:0] ACC_AVG_BASE_SHIFT = 3'h2;
endpackage : aglfc_pkg

// ---- src/aglfc_filter_top.sv ----
// Accelerometer and gyroscope filter, output-rate and low-power averaging logic.
//
// Contract
// - Low-power accelerometer averaging takes 4, 8, 16 or 32 samples for codes 0 to 3.
// - With bypass set the filter is skipped and output runs at 4 kHz, ignoring the select.
// - With bypass clear one of seven responses applies at 1 kHz, codes 0 and 1 alike.
// - The filter output rate is divided by one plus the eight-bit divider setting.
// - In low-power mode the accelerometer is powered only for a window set by averaging.
// - Low-power gyroscope mode is on while the cycle bit is 1, which resets to 0.
// - Low-power gyroscope averaging takes 1 to 128 samples for codes 0 to 7, default 0.
// - In low-power gyroscope mode the gyroscope low-pass select is ignored.
`timescale 1ns/10ps
module aglfc_filter_top #(
	parameter int US_CYCLES = aglfc_pkg::CLK_CYC_PER_US,
	parameter int DATA_W = 16
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic srst,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_r,
	// Settings held elsewhere in the device.
	input wire logic [7:0] rate_divider,
	input wire logic lp_accel_mode,
	input wire logic [2:0] gyro_lpf_sel,
	// Accelerometer samples and output.
	input wire logic accel_in_valid,
	input wire logic signed [DATA_W-1:0] accel_in,
	output logic accel_out_valid_r,
	output logic signed [DATA_W-1:0] accel_out_r,
	output logic accel_power_on_r,
	// Gyroscope samples and output.
	input wire logic gyro_raw_valid,
	input wire logic signed [DATA_W-1:0] gyro_raw,
	input wire logic gyro_filt_valid,
	input wire logic signed [DATA_W-1:0] gyro_filt,
	output logic gyro_out_valid_r,
	output logic signed [DATA_W-1:0] gyro_out_r,
	output logic [2:0] gyro_lpf_eff_r
);
	localparam int ACC_W = DATA_W + 8;
	localparam int T4K_CYC = aglfc_pkg::PERIOD_4K_US * US_CYCLES;
	localparam int T1K_CYC = aglfc_pkg::PERIOD_1K_US * US_CYCLES;

	// Low-pass response per select code; codes 0 and 1 share one response.
	function automatic logic [2:0] lpf_shift(input logic [2:0] sel);
		case (sel)
			3'h0, 3'h1: lpf_shift = 3'h2;
			3'h7: lpf_shift = 3'h1;
			default: lpf_shift = sel + 3'h1;
		endcase
	endfunction

	// Active window length in cycles for the current averaging setting.
	function automatic logic [19:0] ton_cycles(input logic byp, input logic [1:0] avg);
		int us;
		us = aglfc_pkg::TON_32X_US;
		if (byp) begin
			us = aglfc_pkg::TON_1X_US;
		end else if (avg == 2'h0) begin
			us = aglfc_pkg::TON_4X_US;
		end else if (avg == 2'h1) begin
			us = aglfc_pkg::TON_8X_US;
		end else if (avg == 2'h2) begin
			us = aglfc_pkg::TON_16X_US;
		end
		ton_cycles = 20'(us * US_CYCLES);
	endfunction

	logic [7:0] accel_cfg_r, accel_cfg_nxt, gyro_cfg_r, gyro_cfg_nxt, rdata_nxt;
	logic bypass, gyro_cycle;
	logic [1:0] acc_avg_sel;
	logic [2:0] acc_lpf_sel, gyro_avg_sel, acc_shift;

	// Field views of the two registers.
	assign bypass = accel_cfg_r[aglfc_pkg::BYPASS_BIT];
	assign acc_avg_sel = accel_cfg_r[aglfc_pkg::AVG_SEL_LSB +: 2];
	assign acc_lpf_sel = accel_cfg_r[aglfc_pkg::LPF_SEL_LSB +: 3];
	assign gyro_cycle = gyro_cfg_r[aglfc_pkg::GYRO_CYCLE_BIT];
	assign gyro_avg_sel = gyro_cfg_r[aglfc_pkg::GYRO_AVG_LSB +: 3];
	// Single-sample operation when bypassed, otherwise four times two to the select.
	assign acc_shift = bypass ? 3'h0 : aglfc_pkg::ACC_AVG_BASE_SHIFT + {1'b0, acc_avg_sel};

	// Register writes and reads; reserved bits are masked on the way in.
	always_comb begin
		accel_cfg_nxt = accel_cfg_r;
		gyro_cfg_nxt = gyro_cfg_r;
		rdata_nxt = 8'h00;
		if (reg_wr && reg_addr == aglfc_pkg::ACCEL_CFG2_ADDR) begin
			accel_cfg_nxt = reg_wdata & aglfc_pkg::ACCEL_CFG2_MASK;
		end
		if (reg_wr && reg_addr == aglfc_pkg::GYRO_LP_ADDR) begin
			gyro_cfg_nxt = reg_wdata & aglfc_pkg::GYRO_LP_MASK;
		end
		if (reg_rd && reg_addr == aglfc_pkg::ACCEL_CFG2_ADDR) begin
			rdata_nxt = accel_cfg_r;
		end else if (reg_rd && reg_addr == aglfc_pkg::GYRO_LP_ADDR) begin
			rdata_nxt = gyro_cfg_r;
		end
	end

	// Register state; the cycle bit and averaging field clear on reset.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			accel_cfg_r <= aglfc_pkg::ACCEL_CFG2_RST;
			gyro_cfg_r <= aglfc_pkg::GYRO_LP_RST;
			reg_rdata_r <= 8'h00;
		end else begin
			accel_cfg_r <= accel_cfg_nxt;
			gyro_cfg_r <= gyro_cfg_nxt;
			reg_rdata_r <= rdata_nxt;
		end
	end

	logic [19:0] tick_cnt_r, tick_cnt_nxt, ton_cnt_r, ton_cnt_nxt;
	logic [7:0] div_cnt_r, div_cnt_nxt;
	logic [5:0] lp_n_r, lp_n_nxt;
	logic signed [ACC_W-1:0] lp_acc_r, lp_acc_nxt, iir_r, iir_nxt;
	logic signed [DATA_W-1:0] raw_r, raw_nxt, acc_out_nxt;
	logic base_tick, odr_stb, acc_vld_nxt, pwr_nxt;
	logic [19:0] tick_lim;

	// Base filter rate: 4 kHz when bypassed, 1 kHz through the filter.
	assign tick_lim = bypass ? 20'(T4K_CYC - 1) : 20'(T1K_CYC - 1);
	assign base_tick = (tick_cnt_r >= tick_lim);
	assign odr_stb = base_tick && (div_cnt_r == rate_divider);

	// Accelerometer datapath: filter, rate divider and duty-cycled averaging.
	always_comb begin
		tick_cnt_nxt = base_tick ? 20'h00000 : tick_cnt_r + 20'h00001;
		div_cnt_nxt = div_cnt_r;
		if (base_tick) begin
			div_cnt_nxt = odr_stb ? 8'h00 : div_cnt_r + 8'h01;
		end
		raw_nxt = accel_in_valid ? accel_in : raw_r;
		iir_nxt = iir_r;
		if (accel_in_valid) begin
			// A first-order response; the accumulator has no fraction bits, so steps below one count are lost.
			iir_nxt = iir_r + ((ACC_W'(accel_in) - iir_r) >>> lpf_shift(acc_lpf_sel));
		end
		ton_cnt_nxt = ton_cnt_r;
		lp_n_nxt = lp_n_r;
		lp_acc_nxt = lp_acc_r;
		pwr_nxt = accel_power_on_r;
		acc_vld_nxt = 1'b0;
		acc_out_nxt = accel_out_r;
		if (!lp_accel_mode) begin
			pwr_nxt = 1'b1;
			if (odr_stb) begin
				acc_vld_nxt = 1'b1;
				acc_out_nxt = bypass ? raw_r : DATA_W'(iir_r);
			end
		end else if (accel_power_on_r) begin
			if (accel_in_valid && lp_n_r < (6'h01 << acc_shift)) begin
				lp_acc_nxt = lp_acc_r + ACC_W'(accel_in);
				lp_n_nxt = lp_n_r + 6'h01;
			end
			if (ton_cnt_r == 20'h00000) begin
				// Window end: power down and present the average collected so far.
				pwr_nxt = 1'b0;
				acc_vld_nxt = 1'b1;
				acc_out_nxt = DATA_W'(lp_acc_r >>> acc_shift);
			end else begin
				ton_cnt_nxt = ton_cnt_r - 20'h00001;
			end
		end else begin
			pwr_nxt = odr_stb;
			if (odr_stb) begin
				ton_cnt_nxt = ton_cycles(bypass, acc_avg_sel) - 20'h00001;
				lp_n_nxt = 6'h00;
				lp_acc_nxt = '0;
			end
		end
	end

	// Accelerometer state registers.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tick_cnt_r <= 20'h00000;
			div_cnt_r <= 8'h00;
			ton_cnt_r <= 20'h00000;
			lp_n_r <= 6'h00;
			lp_acc_r <= '0;
			iir_r <= '0;
			raw_r <= '0;
			accel_power_on_r <= 1'b0;
			accel_out_valid_r <= 1'b0;
			accel_out_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
			div_cnt_r <= div_cnt_nxt;
			ton_cnt_r <= ton_cnt_nxt;
			lp_n_r <= lp_n_nxt;
			lp_acc_r <= lp_acc_nxt;
			iir_r <= iir_nxt;
			raw_r <= raw_nxt;
			accel_power_on_r <= pwr_nxt;
			accel_out_valid_r <= acc_vld_nxt;
			accel_out_r <= acc_out_nxt;
		end
	end

	logic [6:0] gyro_cnt_r, gyro_cnt_nxt;
	logic signed [ACC_W-1:0] gyro_acc_r, gyro_acc_nxt, gyro_sum;
	logic signed [DATA_W-1:0] gyro_out_nxt;
	logic gyro_vld_nxt;
	logic [2:0] gyro_lpf_nxt;

	// Gyroscope path: block averaging in low-power mode, filtered stream otherwise.
	always_comb begin
		gyro_cnt_nxt = gyro_cnt_r;
		gyro_acc_nxt = gyro_acc_r;
		gyro_vld_nxt = 1'b0;
		gyro_out_nxt = gyro_out_r;
		gyro_sum = gyro_acc_r + ACC_W'(gyro_raw);
		// The external select only matters outside low-power mode.
		gyro_lpf_nxt = gyro_cycle ? 3'h0 : gyro_lpf_sel;
		if (gyro_cycle) begin
			if (gyro_raw_valid) begin
				if (gyro_cnt_r == (7'h7f >> (3'h7 - gyro_avg_sel))) begin
					gyro_vld_nxt = 1'b1;
					gyro_out_nxt = DATA_W'(gyro_sum >>> gyro_avg_sel);
					gyro_cnt_nxt = 7'h00;
					gyro_acc_nxt = '0;
				end else begin
					gyro_cnt_nxt = gyro_cnt_r + 7'h01;
					gyro_acc_nxt = gyro_sum;
				end
			end
		end else begin
			gyro_cnt_nxt = 7'h00;
			gyro_acc_nxt = '0;
			gyro_vld_nxt = gyro_filt_valid;
			gyro_out_nxt = gyro_filt_valid ? gyro_filt : gyro_out_r;
		end
	end

	// Gyroscope state registers.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			gyro_cnt_r <= 7'h00;
			gyro_acc_r <= '0;
			gyro_out_valid_r <= 1'b0;
			gyro_out_r <= '0;
			gyro_lpf_eff_r <= 3'h0;
		end else begin
			gyro_cnt_r <= gyro_cnt_nxt;
			gyro_acc_r <= gyro_acc_nxt;
			gyro_out_valid_r <= gyro_vld_nxt;
			gyro_out_r <= gyro_out_nxt;
			gyro_lpf_eff_r <= gyro_lpf_nxt;
		end
	end

	// Checks on the timing and averaging behaviour.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_lp_avg_bound: assert property (lp_n_r <= (6'h01 << acc_shift))
		else $error("Low-power accelerometer took too many samples.");
	// The first cycle after bypass is set may still hold a count from the slower rate.
	a_bypass_rate: assert property (bypass && $past(bypass) && base_tick
		|-> tick_cnt_r == 20'(T4K_CYC - 1))
		else $error("Bypassed base tick is not 4 kHz.");
	a_filter_rate: assert property (base_tick && !bypass |-> tick_cnt_r == 20'(T1K_CYC - 1))
		else $error("Filtered base tick is not 1 kHz.");
	a_rate_divide: assert property (odr_stb |=> div_cnt_r == 8'h00 && tick_cnt_r == 20'h00000)
		else $error("Rate divider did not restart after an output.");
	a_lp_window: assert property ($fell(accel_power_on_r) && lp_accel_mode
		|-> $past(ton_cnt_r) == 20'h00000 && accel_out_valid_r)
		else $error("Power window ended early or without output.");
	a_cycle_reset: assert property ($past(srst) |-> !gyro_cycle && gyro_avg_sel == 3'h0)
		else $error("Gyroscope low-power fields not cleared by reset.");
	a_gyro_avg: assert property (gyro_out_valid_r && $past(gyro_cycle) && $past(gyro_raw_valid)
		|-> $past(gyro_cnt_r) == (7'h7f >> (3'h7 - $past(gyro_avg_sel))))
		else $error("Gyroscope average emitted with wrong sample count.");
	a_gyro_ignore: assert property (gyro_cycle |=> gyro_lpf_eff_r == 3'h0)
		else $error("Gyroscope low-pass select used in low-power mode.");
	a_reserved_zero: assert property ($past(reg_rd) && $past(reg_addr) == aglfc_pkg::GYRO_LP_ADDR
		|-> reg_rdata_r[3:0] == 4'h0)
		else $error("Reserved register bits read as nonzero.");

	c_lp_accel_out: cover property (lp_accel_mode && accel_out_valid_r);
	c_bypass_out: cover property (bypass && !lp_accel_mode && accel_out_valid_r);
	c_gyro_avg_out: cover property (gyro_cycle && gyro_avg_sel == 3'h3 && gyro_out_valid_r);
endmodule // aglfc_filter_top

// ---- testbench/aglfc_host_model.sv ----
// Host model that reaches the configuration registers.
`timescale 1ns/10ps
module aglfc_host_model (
	// Clock.
	input wire logic sys_clk,
	// Register port.
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata_r
);
	// Strobes are idle at time zero.
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	// One write pulse; the released bus is inverted so no stale byte lingers.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	// One read pulse; the byte stands for one cycle only.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		d = reg_rdata_r;
	endtask
	// Low-power accelerometer setup: bypass alone, or select 7 with averaging.
	task automatic lp_accel(input logic single, input logic [1:0] avg);
		wr(8'h1d, single ? 8'h08 : {2'b00, avg, 4'h7});
	endtask
	// Low-power gyroscope setup always carries the cycle bit.
	task automatic lp_gyro(input logic [2:0] avg);
		wr(8'h1e, {1'b1, avg, 4'h0});
	endtask
endmodule // aglfc_host_model

// ---- testbench/test_aglfc_filter_top.sv ----
// Self-checking bench for the filter configuration block.
`timescale 1ns/10ps
module test_aglfc_filter_top;
	localparam int US = 1;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_r, rv, d;
	logic reg_wr, reg_rd, accel_out_valid_r, accel_power_on_r, gyro_out_valid_r;
	logic [7:0] rate_divider = 8'h00;
	logic lp_accel_mode = 1'b0;
	logic [2:0] gyro_lpf_sel = 3'h0;
	logic [2:0] gyro_lpf_eff_r;
	logic accel_in_valid = 1'b0;
	logic gyro_raw_valid = 1'b0;
	logic gyro_filt_valid = 1'b0;
	logic signed [15:0] accel_in = 16'h0000;
	logic signed [15:0] gyro_raw = 16'h0000;
	logic signed [15:0] gyro_filt = 16'h0000;
	logic signed [15:0] accel_out_r, gyro_out_r;
	int fails = 0;
	int checks_done = 0;
	int n, g;
	int q[$];
	int ton[5] = '{1084, 1840, 2840, 4840, 8840};
	int dv[4] = '{0, 0, 2, 3};
	int gp[4] = '{250, 1000, 3000, 1000};
	aglfc_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));
	aglfc_filter_top #(.US_CYCLES(US), .DATA_W(16)) aglfc_filter_top_inst (.sys_clk(sys_clk),
		.srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .rate_divider(rate_divider),
		.lp_accel_mode(lp_accel_mode), .gyro_lpf_sel(gyro_lpf_sel),
		.accel_in_valid(accel_in_valid), .accel_in(accel_in),
		.accel_out_valid_r(accel_out_valid_r), .accel_out_r(accel_out_r),
		.accel_power_on_r(accel_power_on_r), .gyro_raw_valid(gyro_raw_valid),
		.gyro_raw(gyro_raw), .gyro_filt_valid(gyro_filt_valid), .gyro_filt(gyro_filt),
		.gyro_out_valid_r(gyro_out_valid_r), .gyro_out_r(gyro_out_r),
		.gyro_lpf_eff_r(gyro_lpf_eff_r));
	// Free-running clock.
	always #5 sys_clk = ~sys_clk;
	// Compares one value and reports a mismatch at once.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	// Prints the verdict and ends the run.
	task automatic wrap_up();
		if (fails == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	function automatic logic flag(input int k);
		return k == 0 ? accel_out_valid_r : k == 1 ? accel_power_on_r : gyro_out_valid_r;
	endfunction
	// Counts falling edges until a flag reaches a level; a stuck design ends the run.
	task automatic wait_lvl(input int k, input logic lvl, output int c);
		c = 0;
		while (flag(k) !== lvl) begin
			@(negedge sys_clk);
			c++;
			if (c > 40000) begin
				fails++;
				wrap_up();
			end
		end
	endtask
	// Main sequence.
	initial begin
		void'($urandom(32'hd6aa));
		repeat (12) @(negedge sys_clk);
		srst = 1'b0;
		host.rd(8'h1d, rv);
		check("accel cfg reset", rv, 8'h00);
		host.rd(8'h1e, rv);
		check("gyro cfg reset", rv, 8'h00);
		// All ones first shows the reserved bits, then random bytes; 0x1f is unmapped.
		for (int j = 0; j < 6; j++) begin
			d = j < 3 ? 8'hff : 8'($urandom);
			host.wr(8'h1d + 8'(j % 3), d);
			host.rd(8'h1d + 8'(j % 3), rv);
			check("reg read", rv, j % 3 == 0 ? d & 8'h3f : j % 3 == 1 ? d & 8'hf0 : 8'h00);
		end
		host.wr(8'h1e, 8'h00);
		gyro_lpf_sel = 3'($urandom);
		gyro_filt = 16'($urandom);
		gyro_filt_valid = 1'b1;
		@(negedge sys_clk);
		gyro_filt_valid = 1'b0;
		wait_lvl(2, 1'b1, n);
		check("gyro normal delay", n, 0);
		check("gyro normal data", 16'(gyro_out_r), 16'(gyro_filt));
		check("gyro lpf follows", gyro_lpf_eff_r, gyro_lpf_sel);
		// Every gyroscope averaging code with one full group of random samples.
		for (int a = 0; a < 8; a++) begin
			host.lp_gyro(3'(a));
			q.delete();
			repeat (1 << a) begin
				@(negedge sys_clk);
				gyro_raw = 16'($urandom);
				gyro_raw_valid = 1'b1;
				q.push_back(int'(gyro_raw));
				@(negedge sys_clk);
				gyro_raw_valid = 1'b0;
			end
			wait_lvl(2, 1'b1, n);
			check("gyro lp delay", n, 0);
			check("gyro lp mean", 16'(gyro_out_r), 16'(q.sum() >>> a));
			check("gyro lpf ignored", gyro_lpf_eff_r, 3'h0);
		end
		// Low-noise rates; the first gap after a change may be partial, so the second counts.
		accel_in = 16'($urandom);
		accel_in_valid = 1'b1;
		for (int j = 0; j < 4; j++) begin
			host.wr(8'h1d, (j % 3 == 0 ? 8'h08 : 8'h00) | 8'($urandom % 8));
			rate_divider = 8'(dv[j]);
			for (int k = 0; k < 2; k++) begin
				wait_lvl(0, 1'b1, g);
				@(negedge sys_clk);
				wait_lvl(0, 1'b1, g);
			end
			check("ln gap", g + 1, gp[j]);
			if (j == 0) check("bypass data", 16'(accel_out_r), 16'(accel_in));
			// A settled low-pass output sits at the input or just below it, never above.
			if (j % 3 != 0) begin
				n = int'(accel_in) - int'(accel_out_r);
				check("filtered dc", n inside {[0:127]}, 1'b1);
			end
		end
		// Duty-cycled windows: single sample, then 4 to 32 averages.
		accel_in_valid = 1'b0;
		lp_accel_mode = 1'b1;
		rate_divider = 8'h08;
		for (int j = 0; j < 5; j++) begin
			host.lp_accel(j == 0, 2'(j - 1));
			wait_lvl(1, 1'b0, n);
			wait_lvl(1, 1'b1, n);
			q.delete();
			n = 0;
			while (accel_power_on_r === 1'b1 && n < 9000) begin
				accel_in_valid = n % 8 == 4 && q.size() < (j == 0 ? 1 : 4 << (j - 1));
				accel_in = 16'($urandom);
				if (accel_in_valid) q.push_back(int'(accel_in));
				@(negedge sys_clk);
				n++;
			end
			accel_in_valid = 1'b0;
			check("lp window", n, ton[j] * US);
			check("lp pulse", accel_out_valid_r, 1'b1);
			check("lp mean", 16'(accel_out_r), 16'(q.sum() >>> (j == 0 ? 0 : j + 1)));
		end
		// A reset in mid-run must clear fields that were set, not just ones still at zero.
		host.lp_gyro(3'h5);
		host.rd(8'h1e, rv);
		check("gyro cfg set", rv, 8'hd0);
		@(negedge sys_clk);
		srst = 1'b1;
		repeat (2) @(negedge sys_clk);
		srst = 1'b0;
		host.rd(8'h1e, rv);
		check("gyro cfg re-reset", rv, 8'h00);
		host.rd(8'h1d, rv);
		check("accel cfg re-reset", rv, 8'h00);
		wrap_up();
	end
endmodule // test_aglfc_filter_top
